// >>> hdl/aux_test_output_select.sv
`timescale 1ns/10ps

module aux_test_output_select #(
   parameter int BUS_WIDTH = 8
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // core status, same clock
   input wire aux_test_pkg::link_status_t link_status,
   input wire logic [BUS_WIDTH-1:0] probe_bus,
   input wire logic [3:0] adc_i_sample,
   input wire logic [3:0] adc_q_sample,
   // analogue stage controls
   output logic [5:0] probe_dac_one,
   output logic [5:0] probe_dac_two,
   // auxiliary pins
   output aux_test_pkg::pin_drive_t test_out_pin_one,
   output aux_test_pkg::pin_drive_t test_out_pin_two
);

   logic [3:0] first_pin_source_r, first_pin_source_nxt;
   logic [3:0] second_pin_source_r, second_pin_source_nxt;
   logic [5:0] dac_one_r, dac_one_nxt;
   logic [5:0] dac_two_r, dac_two_nxt;
   logic [7:0] slot_a_r, slot_a_nxt;
   logic [7:0] slot_b_r, slot_b_nxt;
   logic [7:0] slot_c_r, slot_c_nxt;
   logic [7:0] slot_d_r, slot_d_nxt;
   logic [2:0] probe_bus_bit_pick_r, probe_bus_bit_pick_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic ack_r, ack_nxt;
   aux_test_pkg::pin_drive_t pin_one_r, pin_one_nxt;
   aux_test_pkg::pin_drive_t pin_two_r, pin_two_nxt;
   logic probe_bit;
   logic req;
   logic wr_take;

   // one wait state per access: the ack cycle is the only taking edge
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_r;
   assign wr_take = avs_write & ack_r;
   assign avs_readdata = rdata_r;

   // the picked bit; an out-of-range pick reads zero on narrow buses
   assign probe_bit = (32'(probe_bus_bit_pick_r) < BUS_WIDTH) ?
                      probe_bus[probe_bus_bit_pick_r] : 1'b0;

   // per-pin selector decode, shared so both pins decode alike
   function automatic aux_test_pkg::pin_drive_t decode_pin(
      input logic [3:0] code,
      input aux_test_pkg::link_status_t st,
      input logic pbit
   );
      aux_test_pkg::pin_drive_t d;
      d.dout = 1'b0;
      d.oe_n = 1'b1;
      d.route = aux_test_pkg::ROUTE_NONE;
      case (code)
         aux_test_pkg::SEL_HIGH_Z: d.oe_n = 1'b1;
         aux_test_pkg::SEL_DAC: d.route = aux_test_pkg::ROUTE_DAC;
         aux_test_pkg::SEL_CORRELATOR: d.route = aux_test_pkg::ROUTE_CORRELATOR;
         aux_test_pkg::SEL_FLOOR_LEVEL: d.route = aux_test_pkg::ROUTE_FLOOR_LEVEL;
         aux_test_pkg::SEL_ADC_I: d.route = aux_test_pkg::ROUTE_ADC_I;
         aux_test_pkg::SEL_ADC_Q: d.route = aux_test_pkg::ROUTE_ADC_Q;
         aux_test_pkg::SEL_CONST_HIGH:
         begin
            d.oe_n = 1'b0;
            d.dout = 1'b1;
         end
         aux_test_pkg::SEL_CONST_LOW:
         begin
            d.oe_n = 1'b0;
            d.dout = 1'b0;
         end
         aux_test_pkg::SEL_SENDING:
         begin
            d.oe_n = 1'b0;
            d.dout = st.sending;
         end
         aux_test_pkg::SEL_RECEIVING:
         begin
            d.oe_n = 1'b0;
            d.dout = st.receiving;
         end
         aux_test_pkg::SEL_SUBCARRIER:
         begin
            d.oe_n = 1'b0;
            d.dout = st.subcarrier & ~st.low_rate;
         end
         aux_test_pkg::SEL_PROBE_BIT:
         begin
            d.oe_n = 1'b0;
            d.dout = pbit;
         end
         // reserved codes release the pin and route nothing
         default: d.oe_n = 1'b1;
      endcase
      return d;
   endfunction

   // register file next state and read mux
   always_comb
   begin
      first_pin_source_nxt = first_pin_source_r;
      second_pin_source_nxt = second_pin_source_r;
      dac_one_nxt = dac_one_r;
      dac_two_nxt = dac_two_r;
      slot_a_nxt = slot_a_r;
      slot_b_nxt = slot_b_r;
      slot_c_nxt = slot_c_r;
      slot_d_nxt = slot_d_r;
      probe_bus_bit_pick_nxt = probe_bus_bit_pick_r;
      rdata_nxt = rdata_r;
      ack_nxt = req & ~ack_r;
      if (wr_take)
      begin
         case (avs_address)
            aux_test_pkg::OFS_SOURCE_SELECT:
            begin
               first_pin_source_nxt = avs_writedata[aux_test_pkg::FIRST_SRC_LSB +: 4];
               second_pin_source_nxt = avs_writedata[aux_test_pkg::SECOND_SRC_LSB +: 4];
            end
            aux_test_pkg::OFS_DAC_ONE: dac_one_nxt = avs_writedata[5:0];
            aux_test_pkg::OFS_DAC_TWO: dac_two_nxt = avs_writedata[5:0];
            aux_test_pkg::OFS_SLOT_A: slot_a_nxt = avs_writedata[7:0];
            aux_test_pkg::OFS_SLOT_B: slot_b_nxt = avs_writedata[7:0];
            aux_test_pkg::OFS_SLOT_C: slot_c_nxt = avs_writedata[7:0];
            aux_test_pkg::OFS_SLOT_D: slot_d_nxt = avs_writedata[7:0];
            aux_test_pkg::OFS_PROBE_SELECT: probe_bus_bit_pick_nxt = avs_writedata[2:0];
            default: ; // unmapped writes are dropped
         endcase
      end
      // read data prepared in the wait cycle, presented on the ack edge
      if (avs_read & ~ack_r)
      begin
         rdata_nxt = 32'h0;
         case (avs_address)
            aux_test_pkg::OFS_SOURCE_SELECT:
               rdata_nxt[7:0] = {first_pin_source_r, second_pin_source_r};
            aux_test_pkg::OFS_DAC_ONE: rdata_nxt[5:0] = dac_one_r;
            aux_test_pkg::OFS_DAC_TWO: rdata_nxt[5:0] = dac_two_r;
            aux_test_pkg::OFS_ADC_READBACK:
               rdata_nxt[7:0] = {adc_i_sample, adc_q_sample};
            aux_test_pkg::OFS_SLOT_A: rdata_nxt[7:0] = slot_a_r;
            aux_test_pkg::OFS_SLOT_B: rdata_nxt[7:0] = slot_b_r;
            aux_test_pkg::OFS_SLOT_C: rdata_nxt[7:0] = slot_c_r;
            aux_test_pkg::OFS_SLOT_D: rdata_nxt[7:0] = slot_d_r;
            aux_test_pkg::OFS_PROBE_SELECT: rdata_nxt[2:0] = probe_bus_bit_pick_r;
            default: rdata_nxt = 32'h0; // unmapped reads return zero
         endcase
      end
   end

   // pins are registered so the pads see no decode glitches
   always_comb
   begin
      pin_one_nxt = decode_pin(first_pin_source_r, link_status, probe_bit);
      pin_two_nxt = decode_pin(second_pin_source_r, link_status, probe_bit);
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         first_pin_source_r <= aux_test_pkg::RST_SOURCE_SELECT[aux_test_pkg::FIRST_SRC_LSB +: 4];
         second_pin_source_r <= aux_test_pkg::RST_SOURCE_SELECT[aux_test_pkg::SECOND_SRC_LSB +: 4];
         dac_one_r <= aux_test_pkg::RST_DAC;
         dac_two_r <= aux_test_pkg::RST_DAC;
         slot_a_r <= aux_test_pkg::RST_SLOT_A;
         slot_b_r <= aux_test_pkg::RST_SLOT_B;
         slot_c_r <= aux_test_pkg::RST_SLOT_C;
         slot_d_r <= aux_test_pkg::RST_SLOT_D;
         probe_bus_bit_pick_r <= aux_test_pkg::RST_PROBE_PICK;
         rdata_r <= 32'h0;
         ack_r <= 1'b0;
         pin_one_r <= '{dout: 1'b0, oe_n: 1'b1, route: aux_test_pkg::ROUTE_NONE};
         pin_two_r <= '{dout: 1'b0, oe_n: 1'b1, route: aux_test_pkg::ROUTE_NONE};
      end
      else
      begin
         first_pin_source_r <= first_pin_source_nxt;
         second_pin_source_r <= second_pin_source_nxt;
         dac_one_r <= dac_one_nxt;
         dac_two_r <= dac_two_nxt;
         slot_a_r <= slot_a_nxt;
         slot_b_r <= slot_b_nxt;
         slot_c_r <= slot_c_nxt;
         slot_d_r <= slot_d_nxt;
         probe_bus_bit_pick_r <= probe_bus_bit_pick_nxt;
         rdata_r <= rdata_nxt;
         ack_r <= ack_nxt;
         pin_one_r <= pin_one_nxt;
         pin_two_r <= pin_two_nxt;
      end
   end

   assign test_out_pin_one = pin_one_r;
   assign test_out_pin_two = pin_two_r;
   assign probe_dac_one = dac_one_r;
   assign probe_dac_two = dac_two_r;

   // pin follows a constant-high code one edge after the write is taken
   src_high_a: assert property (@(posedge clk_sys) disable iff (srst)
      (first_pin_source_r == aux_test_pkg::SEL_CONST_HIGH) |=> 
      (!test_out_pin_one.oe_n && test_out_pin_one.dout))
      else $error("pin one not high for high code");

   hi_z_a: assert property (@(posedge clk_sys) disable iff (srst)
      (second_pin_source_r == aux_test_pkg::SEL_HIGH_Z) |=> test_out_pin_two.oe_n)
      else $error("pin two driven in high-impedance code");

   dac_route_a: assert property (@(posedge clk_sys) disable iff (srst)
      (first_pin_source_r == aux_test_pkg::SEL_DAC) |=>
      (test_out_pin_one.route == aux_test_pkg::ROUTE_DAC && test_out_pin_one.oe_n))
      else $error("dac not routed to pin one");

   adc_q_a: assert property (@(posedge clk_sys) disable iff (srst)
      (second_pin_source_r == aux_test_pkg::SEL_ADC_Q) |=>
      (test_out_pin_two.route == aux_test_pkg::ROUTE_ADC_Q))
      else $error("q sample not routed to pin two");

   sending_a: assert property (@(posedge clk_sys) disable iff (srst)
      (first_pin_source_r == aux_test_pkg::SEL_SENDING) |=>
      (test_out_pin_one.dout == $past(link_status.sending)))
      else $error("pin one not following sending");

   subcarrier_a: assert property (@(posedge clk_sys) disable iff (srst)
      (first_pin_source_r == aux_test_pkg::SEL_SUBCARRIER && link_status.low_rate) |=>
      !test_out_pin_one.dout)
      else $error("subcarrier shown at lowest rate");

   write_wait_a: assert property (@(posedge clk_sys) disable iff (srst)
      ($rose(avs_write) && !ack_r) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("write not answered after one wait state");

   src_write_a: assert property (@(posedge clk_sys) disable iff (srst)
      (wr_take && avs_address == aux_test_pkg::OFS_SOURCE_SELECT) |=>
      ({first_pin_source_r, second_pin_source_r} == $past(avs_writedata[7:0])))
      else $error("source select write lost");

   adc_read_a: assert property (@(posedge clk_sys) disable iff (srst)
      (avs_read && !ack_r && avs_address == aux_test_pkg::OFS_ADC_READBACK) |=>
      (avs_readdata == {24'h0, $past(adc_i_sample), $past(adc_q_sample)}))
      else $error("adc readback wrong");

   rsvd_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
      (avs_read && !ack_r && avs_address == aux_test_pkg::OFS_DAC_TWO) |=>
      (avs_readdata[31:6] == 26'h0))
      else $error("reserved dac bits not zero");

   const_low_a: assert property (@(posedge clk_sys) disable iff (srst)
      (first_pin_source_r == aux_test_pkg::SEL_CONST_LOW) |=>
      (!test_out_pin_one.oe_n && !test_out_pin_one.dout))
      else $error("pin one not low for low code");

   floor_route_a: assert property (@(posedge clk_sys) disable iff (srst)
      (second_pin_source_r == aux_test_pkg::SEL_FLOOR_LEVEL) |=>
      (test_out_pin_two.route == aux_test_pkg::ROUTE_FLOOR_LEVEL && test_out_pin_two.oe_n))
      else $error("floor level not routed to pin two");

   receiving_a: assert property (@(posedge clk_sys) disable iff (srst)
      (second_pin_source_r == aux_test_pkg::SEL_RECEIVING) |=>
      (!test_out_pin_two.oe_n && test_out_pin_two.dout == $past(link_status.receiving)))
      else $error("pin two not following receiving");

   probe_pin_a: assert property (@(posedge clk_sys) disable iff (srst)
      (first_pin_source_r == aux_test_pkg::SEL_PROBE_BIT) |=>
      (!test_out_pin_one.oe_n && test_out_pin_one.dout == $past(probe_bit)))
      else $error("pin one not showing picked bus bit");

   dac_two_route_a: assert property (@(posedge clk_sys) disable iff (srst)
      (second_pin_source_r == aux_test_pkg::SEL_DAC) |=>
      (test_out_pin_two.route == aux_test_pkg::ROUTE_DAC && test_out_pin_two.oe_n))
      else $error("dac two not routed to pin two");

   rsvd_code_a: assert property (@(posedge clk_sys) disable iff (srst)
      (first_pin_source_r inside {4'h3, 4'h7, 4'h8, 4'h9}) |=>
      (test_out_pin_one.oe_n && test_out_pin_one.route == aux_test_pkg::ROUTE_NONE))
      else $error("reserved code had an effect on pin one");

endmodule

// >>> hdl/aux_test_pkg.sv
package aux_test_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_SOURCE_SELECT = 8'h38;
   localparam logic [7:0] OFS_DAC_ONE = 8'h39;
   localparam logic [7:0] OFS_DAC_TWO = 8'h3a;
   localparam logic [7:0] OFS_ADC_READBACK = 8'h3b;
   localparam logic [7:0] OFS_SLOT_A = 8'h3c;
   localparam logic [7:0] OFS_SLOT_B = 8'h3d;
   localparam logic [7:0] OFS_SLOT_C = 8'h3e;
   localparam logic [7:0] OFS_SLOT_D = 8'h3f;
   localparam logic [7:0] OFS_PROBE_SELECT = 8'h40;

   // field positions
   localparam int FIRST_SRC_LSB = 4;
   localparam int SECOND_SRC_LSB = 0;
   localparam int ADC_I_LSB = 4;
   localparam int ADC_Q_LSB = 0;

   // reset values
   localparam logic [7:0] RST_SOURCE_SELECT = 8'h00;
   localparam logic [5:0] RST_DAC = 6'h00;
   localparam logic [7:0] RST_SLOT_A = 8'hff;
   localparam logic [7:0] RST_SLOT_B = 8'h00;
   localparam logic [7:0] RST_SLOT_C = 8'h03;
   localparam logic [7:0] RST_SLOT_D = 8'h00;
   localparam logic [2:0] RST_PROBE_PICK = 3'h0;

   // selector encodings shared by both pins
   localparam logic [3:0] SEL_HIGH_Z = 4'h0;
   localparam logic [3:0] SEL_DAC = 4'h1;
   localparam logic [3:0] SEL_CORRELATOR = 4'h2;
   localparam logic [3:0] SEL_FLOOR_LEVEL = 4'h4;
   localparam logic [3:0] SEL_ADC_I = 4'h5;
   localparam logic [3:0] SEL_ADC_Q = 4'h6;
   localparam logic [3:0] SEL_CONST_HIGH = 4'ha;
   localparam logic [3:0] SEL_CONST_LOW = 4'hb;
   localparam logic [3:0] SEL_SENDING = 4'hc;
   localparam logic [3:0] SEL_RECEIVING = 4'hd;
   localparam logic [3:0] SEL_SUBCARRIER = 4'he;
   localparam logic [3:0] SEL_PROBE_BIT = 4'hf;

   // analogue route code for the current-source output stage
   typedef enum logic [2:0] {
      ROUTE_NONE,
      ROUTE_DAC,
      ROUTE_CORRELATOR,
      ROUTE_FLOOR_LEVEL,
      ROUTE_ADC_I,
      ROUTE_ADC_Q
   } analog_route_t;

   // one auxiliary pin's drive
   typedef struct packed {
      logic dout;
      logic oe_n;
      analog_route_t route;
   } pin_drive_t;

   // status from the transceiver core
   typedef struct packed {
      logic sending;
      logic receiving;
      logic subcarrier;
      logic low_rate;
   } link_status_t;

endpackage

// >>> tb/aux_pin_observer.sv
`timescale 1ns/10ps

// bench equipment watching one auxiliary pin
module aux_pin_observer (
   // pin under observation
   input wire aux_test_pkg::pin_drive_t pin,
   // what the equipment sees
   output logic level,
   output aux_test_pkg::analog_route_t route_seen
);
   // a released pin sinks through the pull-down, so a stale dout never shows
   assign level = pin.oe_n ? 1'b0 : pin.dout;
   // the current source only means something while the digital driver is off
   assign route_seen = pin.oe_n ? pin.route : aux_test_pkg::ROUTE_NONE;
endmodule

// >>> tb/testbench.sv
`timescale 1ns/10ps

module testbench;
   logic clk_sys, srst, avs_read, avs_write, avs_waitrequest, level_one, level_two;
   logic [7:0] avs_address, probe_bus, a;
   logic [31:0] avs_writedata, avs_readdata, rd, rnd;
   aux_test_pkg::link_status_t link_status;
   logic [3:0] adc_i_sample, adc_q_sample;
   logic [5:0] probe_dac_one, probe_dac_two;
   aux_test_pkg::pin_drive_t test_out_pin_one, test_out_pin_two;
   aux_test_pkg::analog_route_t seen_one, seen_two;
   logic [7:0] mdl [0:255];
   int failures, samples_checked, cycles, seed, c;

   aux_test_output_select #(.BUS_WIDTH(8)) aux_test_output_select_i (.clk_sys(clk_sys),
      .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .link_status(link_status), .probe_bus(probe_bus),
      .adc_i_sample(adc_i_sample), .adc_q_sample(adc_q_sample),
      .probe_dac_one(probe_dac_one), .probe_dac_two(probe_dac_two),
      .test_out_pin_one(test_out_pin_one), .test_out_pin_two(test_out_pin_two));
   aux_pin_observer obs_one (.pin(test_out_pin_one), .level(level_one), .route_seen(seen_one));
   aux_pin_observer obs_two (.pin(test_out_pin_two), .level(level_two), .route_seen(seen_two));

   // 125 mhz
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // hang guard, far beyond the thousand or so cycles the run needs
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         failures++;
         $display("Error at %0t: timeout", $time);
         stop_test;
      end
   end

   task automatic stop_test;
      $display("failures=%0d samples_checked=%0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic check_reg(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         failures++;
         $display("Error at %0t: value got %h expected %h", $time, g, e);
      end
   endtask

   task automatic check_pin(input aux_test_pkg::pin_drive_t g, input logic lvl,
      input aux_test_pkg::analog_route_t seen, input aux_test_pkg::pin_drive_t e);
      samples_checked++;
      if (g.oe_n !== e.oe_n || g.route !== e.route || (!e.oe_n && g.dout !== e.dout) ||
          lvl !== (!e.oe_n & e.dout) || seen !== e.route)
      begin
         failures++;
         $display("Error at %0t: pin got %h expected %h", $time, g, e);
      end
   endtask

   // expected drive of a pin for a source code; dout only matters while driven
   function automatic aux_test_pkg::pin_drive_t pin_exp(input logic [3:0] s);
      aux_test_pkg::pin_drive_t e;
      logic [2:0] r;
      // analogue codes 1,2 map to route 1,2 and codes 4..6 to routes 3..5
      r = (s inside {4'h1, 4'h2}) ? s[2:0] : (s inside {[4'h4:4'h6]}) ? s[2:0] - 3'h1 : 3'h0;
      e.route = aux_test_pkg::analog_route_t'(r);
      e.oe_n = (s < 4'ha);
      case (s)
         4'ha: e.dout = 1'b1;
         4'hc: e.dout = link_status.sending;
         4'hd: e.dout = link_status.receiving;
         4'he: e.dout = link_status.subcarrier & ~link_status.low_rate;
         4'hf: e.dout = probe_bus[mdl[8'h40][2:0]];
         default: e.dout = 1'b0;
      endcase
      return e;
   endfunction

   function automatic logic [31:0] expd(input logic [7:0] x);
      return {24'h0, (x == 8'h3b) ? {adc_i_sample, adc_q_sample} : mdl[x]};
   endfunction

   task automatic reset_model;
      foreach (mdl[i]) mdl[i] = 8'h00;
      mdl[8'h3c] = 8'hff;
      mdl[8'h3e] = 8'h03;
   endtask

   // one avalon transfer; the request stands until waitrequest is sampled low at a rising edge
   task automatic bus(input logic is_wr, input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk_sys);
      avs_address <= ad;
      avs_write <= is_wr;
      avs_read <= !is_wr;
      avs_writedata <= {24'h0, d};
      // no cycle count assumed: only the hang guard ends this wait
      do
      begin
         @(posedge clk_sys);
      end
      while (avs_waitrequest !== 1'b0);
      // read data is taken at the accepting edge, then the request is dropped
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   // write and track; read-only and unmapped places keep the model untouched
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      bus(1'b1, ad, d);
      if (ad inside {[8'h38:8'h40]} && ad != 8'h3b)
         mdl[ad] = d & ((ad inside {8'h39, 8'h3a}) ? 8'h3f : (ad == 8'h40) ? 8'h07 : 8'hff);
   endtask

   task automatic read_all;
      for (a = 8'h36; a <= 8'h42; a++)
      begin
         bus(1'b0, a, 8'h00);
         check_reg(rd, expd(a));
      end
   endtask

   task automatic shake;
      @(posedge clk_sys);
      rnd = $random(seed);
      link_status <= rnd[3:0];
      probe_bus <= rnd[11:4];
      adc_i_sample <= rnd[15:12];
      adc_q_sample <= rnd[19:16];
   endtask

   // pins settle one edge after their cause; three edges leave margin
   task automatic pins_chk;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      check_pin(test_out_pin_one, level_one, seen_one, pin_exp(mdl[8'h38][7:4]));
      check_pin(test_out_pin_two, level_two, seen_two, pin_exp(mdl[8'h38][3:0]));
      check_reg({26'h0, probe_dac_one}, {24'h0, mdl[8'h39]});
      check_reg({26'h0, probe_dac_two}, {24'h0, mdl[8'h3a]});
   endtask

   initial
   begin
      seed = 32'h3ba6a709;
      failures = 0;
      samples_checked = 0;
      srst = 1'b1;
      {avs_address, avs_read, avs_write, avs_writedata} = '0;
      {link_status, probe_bus, adc_i_sample, adc_q_sample} = '0;
      reset_model;
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      // reset values, unmapped neighbours included
      read_all;
      pins_chk;
      // random writes everywhere, reserved bits and read-only place too
      repeat (4)
      begin
         for (a = 8'h36; a <= 8'h42; a++)
         begin
            rnd = $random(seed);
            wr(a, rnd[7:0]);
         end
         shake;
         read_all;
         pins_chk;
      end
      // every selector code on both pins against varying status
      for (c = 0; c < 16; c++)
      begin
         wr(8'h38, {c[3:0], c[3:0]});
         repeat (4)
         begin
            shake;
            pins_chk;
         end
      end
      // unlike codes on the two pins
      repeat (24)
      begin
         rnd = $random(seed);
         wr(8'h38, rnd[7:0]);
         shake;
         pins_chk;
      end
      // reset in mid-run restores defaults
      @(posedge clk_sys);
      srst <= 1'b1;
      @(posedge clk_sys);
      srst <= 1'b0;
      reset_model;
      read_all;
      pins_chk;
      stop_test;
   end
endmodule
